/* design/cmbf_pkg.sv */
package cmbf_pkg;

    localparam int MSG_BYTES   = 13;
    localparam int LOCAL_PRIORITY_W      = 8;
    localparam int NUM_TXB     = 3;
    localparam int ERR_CNT_W   = 9;
    localparam logic [ERR_CNT_W-1:0] WARN_LIMIT    = 9'h060;
    localparam logic [ERR_CNT_W-1:0] PASSIVE_LIMIT = 9'h07f;
    localparam logic [ERR_CNT_W-1:0] BUSOFF_LIMIT  = 9'h0ff;
    localparam logic [1:0] RST_FILTER_MODE = 2'h0;
    localparam logic [2:0] RST_TX_EMPTY    = 3'h7;
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DUAL   = 2'h1;
    localparam logic [1:0] MODE_QUAD   = 2'h2;

    // Message image as the link engine delivers and takes it
    typedef struct packed {
        logic [28:0] id;
        logic        ide;
        logic        rtr;
        logic        srr;
        logic [3:0]  dlc;
        logic [63:0] data;
    } cmbf_msg_t;

    // Error-type flags, one bit each
    typedef struct packed {
        logic overrun;
        logic bus_off;
        logic tx_passive;
        logic rx_passive;
        logic tx_warning;
        logic rx_warning;
    } cmbf_err_t;

endpackage : cmbf_pkg

/* design/cmbf_core.sv */
`timescale 1ns/1ps
// Functional notes
// R01: Both buffers full: drop frame, flag overrun
// R02: Background capture ignores the filter result
// R03: Overrun keeps transmit going, drops reception
// R04: Own frames: no transfer, interrupt or ack
// R05: Loop-back treats own frames as received
// R06: Three transmit images with 8-bit priority
// R07: Host loads buffer then clears empty flag
// R08: Sent buffer sets empty flag, interrupts
// R09: Lowest priority value wins each arbitration
// R10: Abort if not on bus, acknowledge, empty
// R11: Single filter: 29 ids plus RTR IDE SRR
// R12: Dual filter: 11+RTR or top 14 bits
// R13: Quad filter: first 8 standard id bits
// R14: Mask bit set means identifier bit ignored
// R15: Only a filter hit transfers and sets full
// R16: Hit index reports lowest matching filter
// R17: Receive interrupt right after end of frame
// R18: Bus activity during sleep sets wakeup flag
// R19: Warning flags at error count 96
// R20: Passive above 127, bus-off above 255
// R21: Write-one clears, ignored while condition holds
// R22: Eleven gated sources onto four request lines
// R23: Transfer only while full flag clear
// R24: Host reads then clears full flag
// R25: Transmit pin low dominant, high recessive
// R26: Equal priorities pick lowest buffer index
module cmbf_core
    import cmbf_pkg::*;
#(
    parameter int NTX = 3
) (
    input  wire logic                        CLOCK,
    input  wire logic                        RST_N,
    input  wire logic [1:0]                  FILTER_MODE,
    input  wire logic [31:0]                 FILTER_PATTERN,
    input  wire logic [31:0]                 FILTER_MASK,
    input  wire logic                        LOOPBACK,
    input  wire logic                        RX_VALID,
    input  wire cmbf_pkg::cmbf_msg_t         RX_MSG,
    input  wire logic                        RX_OWN,
    output logic                             RX_ACK_EN,
    output cmbf_pkg::cmbf_msg_t              RX_HOST_BUFFER,
    output logic                             RX_FULL_FLAG,
    output logic [1:0]                       FILTER_HIT_INDEX,
    input  wire logic                        RX_FULL_CLEAR,
    input  wire logic [NTX-1:0]              TX_LOAD,
    input  wire cmbf_pkg::cmbf_msg_t         TX_LOAD_MSG,
    input  wire logic [7:0]                  TX_LOAD_LOCAL_PRIORITY,
    input  wire logic [NTX-1:0]              TX_SCHEDULE,
    input  wire logic [NTX-1:0]              ABORT_REQUEST,
    output logic [NTX-1:0]                   TX_EMPTY_FLAG,
    output logic [NTX-1:0]                   ABORT_ACKNOWLEDGE,
    input  wire logic                        ARB_START,
    input  wire logic                        TX_DONE,
    input  wire logic                        TX_ERROR,
    output logic                             TX_REQ_VALID,
    input  wire logic                        TX_REQ_READY,
    output cmbf_pkg::cmbf_msg_t              TX_REQ_MSG,
    input  wire logic                        TX_BIT,
    output logic                             BUS_TX_PIN,
    input  wire logic                        SLEEP_MODE,
    input  wire logic                        BUS_RX_PIN,
    input  wire logic [8:0]                  RX_ERR_CNT,
    input  wire logic [8:0]                  TX_ERR_CNT,
    input  wire logic [6:0]                  FLAG_CLEAR,
    input  wire logic [6:0]                  IRQ_EN,
    input  wire logic [NTX-1:0]              TX_EMPTY_IRQ_EN,
    input  wire logic                        RX_FULL_IRQ_EN,
    input  wire logic                        GLOBAL_IRQ_EN,
    output logic                             WAKEUP_FLAG,
    output cmbf_pkg::cmbf_err_t              ERR_FLAGS,
    output logic                             IRQ_WAKEUP,
    output logic                             IRQ_ERROR,
    output logic                             IRQ_RX,
    output logic                             IRQ_TX
);
    import cmbf_pkg::*;

    // Storage
    cmbf_msg_t      bg_reg, bg_next, fg_reg, fg_next;
    logic           bg_full_reg, bg_full_next, rxf_reg, rxf_next;
    logic [1:0]     hit_reg, hit_next, bg_hit_reg, bg_hit_next;
    cmbf_msg_t      txm_reg [NTX], txm_next [NTX];
    logic [7:0]     local_priority_reg [NTX], local_priority_next [NTX];
    logic [NTX-1:0] empty_reg, empty_next, abak_reg, abak_next;
    logic [1:0]     sel_reg, sel_next;
    logic           busy_reg, busy_next;
    logic           wak_reg, wak_next;
    cmbf_err_t      err_reg, err_next;
    logic           rx_s1_reg, rx_s2_reg, rx_s3_reg;

    // Acceptance filter: mask bit set means don't care
    function automatic logic fmatch(input logic [31:0] v, input logic [31:0] p,
                                    input logic [31:0] m, input logic [31:0] w);
        return (((v ^ p) & ~m) & w) == 32'h0; // R14
    endfunction : fmatch

    logic [31:0] cmp_word;
    logic        hit;
    logic [1:0]  hit_idx;
    always_comb begin
        cmp_word = RX_MSG.ide ? {RX_MSG.id, RX_MSG.srr, RX_MSG.ide, RX_MSG.rtr}
                              : {RX_MSG.id[10:0], RX_MSG.rtr, RX_MSG.ide, 19'h0};
        hit      = 1'b0;
        hit_idx  = 2'h0;
        case (FILTER_MODE)
            MODE_SINGLE: hit = RX_MSG.ide && fmatch(cmp_word, FILTER_PATTERN, FILTER_MASK,
                                                    32'hffff_ffff); // R11
            MODE_DUAL: begin
                // Standard: 11 id + RTR + IDE; extended: 14 top id bits; lower filter wins
                for (int f = 0; f <= 1; f++) begin
                    if (fmatch({cmp_word[31:16], 16'h0}, {FILTER_PATTERN[16*f +: 16], 16'h0},
                               {FILTER_MASK[16*f +: 16], 16'h0},
                               RX_MSG.ide ? 32'hfffc_0000 : 32'hfff8_0000)) begin // R12
                        hit     = 1'b1;
                        hit_idx = 2'(1 - f); // R16
                    end
                end
            end
            MODE_QUAD: begin
                for (int f = 0; f <= 3; f++) begin
                    if (!RX_MSG.ide && fmatch({cmp_word[31:24], 24'h0},
                            {FILTER_PATTERN[8*f +: 8], 24'h0}, {FILTER_MASK[8*f +: 8], 24'h0},
                            32'hff00_0000)) begin // R13
                        hit     = 1'b1;
                        hit_idx = 2'(3 - f); // R16
                    end
                end
            end
            default: hit = 1'b0;
        endcase
    end

    // Receive path
    logic own_drop, treat_rx;
    assign own_drop  = RX_OWN && !LOOPBACK; // R04
    assign treat_rx  = RX_VALID && !own_drop; // R05
    assign RX_ACK_EN = !own_drop; // R04

    always_comb begin
        bg_next      = bg_reg;
        bg_full_next = bg_full_reg;
        fg_next      = fg_reg;
        rxf_next     = rxf_reg && !RX_FULL_CLEAR; // R24
        hit_next     = hit_reg;
        bg_hit_next  = bg_hit_reg;
        err_next     = err_reg;
        if (bg_full_reg && !rxf_reg) begin
            fg_next      = bg_reg; // R23
            rxf_next     = 1'b1;
            hit_next     = bg_hit_reg; // R16
            bg_full_next = 1'b0;
        end
        if (RX_VALID && bg_full_reg && rxf_reg) begin
            err_next.overrun = err_reg.overrun || treat_rx; // R01 R03
        end else if (RX_VALID) begin
            bg_next      = RX_MSG; // R02
            bg_hit_next  = hit_idx;
            bg_full_next = treat_rx && hit; // R15
        end
        // Straight to an idle host buffer only when nothing is queued ahead of it
        if (RX_VALID && treat_rx && hit && !rxf_reg && !bg_full_reg) begin
            fg_next      = RX_MSG; // R15 R17
            rxf_next     = 1'b1;
            hit_next     = hit_idx; // R16
            bg_full_next = 1'b0;
        end
        // Set wins over clear; clear ignored while condition holds
        if (FLAG_CLEAR[0]) err_next.rx_warning = 1'b0;
        if (FLAG_CLEAR[1]) err_next.tx_warning = 1'b0;
        if (FLAG_CLEAR[2]) err_next.rx_passive = 1'b0;
        if (FLAG_CLEAR[3]) err_next.tx_passive = 1'b0;
        if (FLAG_CLEAR[4]) err_next.bus_off    = 1'b0;
        if (FLAG_CLEAR[5] && !(RX_VALID && bg_full_reg && rxf_reg && treat_rx))
            err_next.overrun = 1'b0; // R21
        if (RX_ERR_CNT >= WARN_LIMIT)    err_next.rx_warning = 1'b1; // R19 R21
        if (TX_ERR_CNT >= WARN_LIMIT)    err_next.tx_warning = 1'b1; // R19
        if (RX_ERR_CNT >  PASSIVE_LIMIT) err_next.rx_passive = 1'b1; // R20
        if (TX_ERR_CNT >  PASSIVE_LIMIT) err_next.tx_passive = 1'b1; // R20
        if (TX_ERR_CNT >  BUSOFF_LIMIT)  err_next.bus_off    = 1'b1; // R20
        wak_next = (wak_reg && !FLAG_CLEAR[6]) || (SLEEP_MODE && (rx_s3_reg != rx_s2_reg)); // R18
    end

    // Transmit scheduling
    logic [1:0] best;
    logic       any_sched;
    always_comb begin
        best      = 2'h0;
        any_sched = 1'b0;
        for (int b = 0; b < NTX; b++) begin
            if (!empty_reg[b] && (!any_sched || local_priority_reg[b] < local_priority_reg[best])) begin // R09 R26
                best      = 2'(b);
                any_sched = 1'b1;
            end
        end
    end

    // Single request register: busy_reg holds the request until the engine reports done or error
    assign TX_REQ_VALID = busy_reg;
    assign TX_REQ_MSG   = txm_reg[sel_reg];

    always_comb begin
        for (int b = 0; b < NTX; b++) begin
            txm_next[b]  = TX_LOAD[b] && empty_reg[b] ? TX_LOAD_MSG : txm_reg[b]; // R06 R07
            local_priority_next[b] = TX_LOAD[b] && empty_reg[b] ? TX_LOAD_LOCAL_PRIORITY : local_priority_reg[b];
        end
        empty_next = empty_reg & ~TX_SCHEDULE; // R07
        abak_next  = abak_reg & ~TX_SCHEDULE;
        sel_next   = sel_reg;
        busy_next  = busy_reg;
        if (ARB_START && any_sched && !busy_reg) begin
            sel_next  = best; // R09
            busy_next = 1'b1;
        end
        if (busy_reg && (TX_DONE || TX_ERROR)) begin
            busy_next = 1'b0; // Error retries reschedule at next arbitration
            if (TX_DONE) begin
                empty_next[sel_reg] = 1'b1; // R08
                abak_next[sel_reg]  = 1'b0; // R10
            end
        end
        for (int b = 0; b < NTX; b++) begin
            if (ABORT_REQUEST[b] && !empty_reg[b] && !(busy_reg && sel_reg == 2'(b))) begin
                empty_next[b] = 1'b1; // R10
                abak_next[b]  = 1'b1;
            end
        end
    end

    assign BUS_TX_PIN = busy_reg && TX_REQ_READY ? TX_BIT : 1'b1; // R25

    always_ff @(posedge CLOCK) begin
        rx_s1_reg <= BUS_RX_PIN;
        rx_s2_reg <= rx_s1_reg;
        rx_s3_reg <= rx_s2_reg;
        if (!RST_N) begin
            bg_full_reg <= 1'b0;
            rxf_reg     <= 1'b0;
            hit_reg     <= 2'h0;
            bg_hit_reg  <= 2'h0;
            empty_reg   <= RST_TX_EMPTY[NTX-1:0];
            abak_reg    <= '0;
            sel_reg     <= 2'h0;
            busy_reg    <= 1'b0;
            wak_reg     <= 1'b0;
            err_reg     <= '0;
            bg_reg      <= '0;
            fg_reg      <= '0;
            for (int b = 0; b < NTX; b++) begin
                txm_reg[b]  <= '0;
                local_priority_reg[b] <= 8'h0;
            end
        end else begin
            bg_full_reg <= bg_full_next;
            rxf_reg     <= rxf_next;
            hit_reg     <= hit_next;
            bg_hit_reg  <= bg_hit_next;
            empty_reg   <= empty_next;
            abak_reg    <= abak_next;
            sel_reg     <= sel_next;
            busy_reg    <= busy_next;
            wak_reg     <= wak_next;
            err_reg     <= err_next;
            bg_reg      <= bg_next;
            fg_reg      <= fg_next;
            for (int b = 0; b < NTX; b++) begin
                txm_reg[b]  <= txm_next[b];
                local_priority_reg[b] <= local_priority_next[b];
            end
        end
    end

    assign RX_HOST_BUFFER    = fg_reg;
    assign RX_FULL_FLAG      = rxf_reg;
    assign FILTER_HIT_INDEX  = hit_reg;
    assign TX_EMPTY_FLAG     = empty_reg;
    assign ABORT_ACKNOWLEDGE = abak_reg;
    assign WAKEUP_FLAG       = wak_reg;
    assign ERR_FLAGS         = err_reg;

    // Interrupt lines, all behind the global mask
    assign IRQ_WAKEUP = GLOBAL_IRQ_EN && wak_reg && IRQ_EN[6]; // R22
    assign IRQ_ERROR  = GLOBAL_IRQ_EN && |(err_reg & IRQ_EN[5:0]); // R22 R01
    assign IRQ_RX     = GLOBAL_IRQ_EN && rxf_reg && RX_FULL_IRQ_EN; // R15 R17
    assign IRQ_TX     = GLOBAL_IRQ_EN && |(empty_reg & TX_EMPTY_IRQ_EN); // R08 R10

    property p_overrun;
        @(posedge CLOCK) disable iff (!RST_N)
        (RX_VALID && treat_rx && bg_full_reg && rxf_reg) |=> ERR_FLAGS.overrun;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // R01

    property p_warn;
        @(posedge CLOCK) disable iff (!RST_N)
        (TX_ERR_CNT >= WARN_LIMIT) |=> ERR_FLAGS.tx_warning;
    endproperty
    a_warn: assert property (p_warn) else $error("tx warning missing"); // R19

    property p_busoff;
        @(posedge CLOCK) disable iff (!RST_N)
        (TX_ERR_CNT > BUSOFF_LIMIT) |=> ERR_FLAGS.bus_off;
    endproperty
    a_busoff: assert property (p_busoff) else $error("bus-off missing"); // R20

    property p_own;
        @(posedge CLOCK) disable iff (!RST_N)
        (RX_VALID && RX_OWN && !LOOPBACK && !rxf_reg && !bg_full_reg) |=> !rxf_reg;
    endproperty
    a_own: assert property (p_own) else $error("own frame reached host"); // R04

    property p_accept;
        @(posedge CLOCK) disable iff (!RST_N)
        (RX_VALID && treat_rx && hit && !rxf_reg && !bg_full_reg) |=>
            (rxf_reg && hit_reg == $past(hit_idx));
    endproperty
    a_accept: assert property (p_accept) else $error("accepted frame lost"); // R15

    property p_keep;
        @(posedge CLOCK) disable iff (!RST_N)
        (rxf_reg && !RX_FULL_CLEAR) |=> (rxf_reg && $stable(fg_reg));
    endproperty
    a_keep: assert property (p_keep) else $error("host buffer overwritten"); // R23

    property p_done;
        @(posedge CLOCK) disable iff (!RST_N)
        (busy_reg && TX_DONE) |=> empty_reg[$past(sel_reg)];
    endproperty
    a_done: assert property (p_done) else $error("sent buffer not empty"); // R08

    property p_pin;
        @(posedge CLOCK) disable iff (!RST_N)
        !busy_reg |-> BUS_TX_PIN;
    endproperty
    a_pin: assert property (p_pin) else $error("pin dominant while idle"); // R25

endmodule : cmbf_core

/* tb/cmbf_engine_model.sv */
`timescale 1ns/1ps
module cmbf_engine_model (
    input  wire logic       CLOCK,
    input  wire logic       RST_N,
    input  wire logic       TX_REQ_VALID,
    input  wire logic [3:0] DELAY,
    output logic            TX_REQ_READY,
    output logic            TX_DONE,
    output logic            TX_BIT
);
    logic [3:0] cnt_reg;
    // Ready holds off for a cycle, so a late engine is seen on every frame
    assign TX_REQ_READY = TX_REQ_VALID && (cnt_reg != 4'h0);
    always_ff @(posedge CLOCK) begin
        if (!RST_N || !TX_REQ_VALID || TX_DONE) begin
            cnt_reg <= 4'h0;
            TX_DONE <= 1'h0;
            TX_BIT  <= 1'h1;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
            TX_DONE <= (cnt_reg == DELAY);
            // Bits change every cycle so a stuck pin cannot match by luck
            TX_BIT  <= ~TX_BIT;
        end
    end
endmodule : cmbf_engine_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    import cmbf_pkg::*;
    logic clock = 1'h0, rst_n = 1'h0, lb = 1'h0, rxv = 1'h0, rxo = 1'h0, rfc = 1'h0;
    logic arb = 1'h0, txer = 1'h0, slp = 1'h0, brx = 1'h1, gie = 1'h1, rfie = 1'h1, ak;
    logic [1:0] fm = 2'h0;
    logic [31:0] fp = 32'h0, fk = 32'h0;
    cmbf_msg_t rxm = '0, tlm = '0, host, treq, a, c, s;
    logic [7:0] tlp = 8'h0;
    logic [2:0] tld = 3'h0, tsc = 3'h0, abr = 3'h0, teie = 3'h7, emp, aak;
    logic [8:0] rec = 9'h0, tec = 9'h0;
    logic [6:0] fcl = 7'h0, ien = 7'h7f;
    logic [3:0] dly = 4'h2;
    logic ack_en, full, irx, iwk, ierr, itx, rdy, done, tbit, pin, wkf, vld;
    logic [1:0] hit;
    cmbf_err_t ef;
    int err_count = 0, n_compared = 0;
    logic [8:0] ev [6] = '{9'h05f, 9'h060, 9'h07f, 9'h080, 9'h0ff, 9'h100};
    logic [7:0] pr [3] = '{8'h7f, 8'h80, 8'h80};
    always #10 clock = ~clock;
    cmbf_core u_dut (.CLOCK(clock), .RST_N(rst_n), .FILTER_MODE(fm), .FILTER_PATTERN(fp),
        .FILTER_MASK(fk), .LOOPBACK(lb), .RX_VALID(rxv), .RX_MSG(rxm), .RX_OWN(rxo),
        .RX_ACK_EN(ack_en), .RX_HOST_BUFFER(host), .RX_FULL_FLAG(full),
        .FILTER_HIT_INDEX(hit), .RX_FULL_CLEAR(rfc), .TX_LOAD(tld), .TX_LOAD_MSG(tlm),
        .TX_LOAD_LOCAL_PRIORITY(tlp), .TX_SCHEDULE(tsc), .ABORT_REQUEST(abr), .TX_EMPTY_FLAG(emp),
        .ABORT_ACKNOWLEDGE(aak), .ARB_START(arb), .TX_DONE(done), .TX_ERROR(txer),
        .TX_REQ_VALID(vld), .TX_REQ_READY(rdy), .TX_REQ_MSG(treq), .TX_BIT(tbit),
        .BUS_TX_PIN(pin), .SLEEP_MODE(slp), .BUS_RX_PIN(brx), .RX_ERR_CNT(rec),
        .TX_ERR_CNT(tec), .FLAG_CLEAR(fcl), .IRQ_EN(ien), .TX_EMPTY_IRQ_EN(teie),
        .RX_FULL_IRQ_EN(rfie), .GLOBAL_IRQ_EN(gie), .WAKEUP_FLAG(wkf), .ERR_FLAGS(ef),
        .IRQ_WAKEUP(iwk), .IRQ_ERROR(ierr), .IRQ_RX(irx), .IRQ_TX(itx));
    cmbf_engine_model u_eng (.CLOCK(clock), .RST_N(rst_n), .TX_REQ_VALID(vld),
        .DELAY(dly), .TX_REQ_READY(rdy), .TX_DONE(done), .TX_BIT(tbit));
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [99:0] e, input logic [99:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    function automatic cmbf_msg_t mk(input logic e, input logic [28:0] id);
        mk = '0;
        mk.id = id;
        mk.ide = e;
        mk.srr = e;
        mk.dlc = 4'h8;
        mk.data = 64'h0123456789abcdef ^ {35'h0, id};
    endfunction : mk
    task automatic rx(input cmbf_msg_t m, input logic own);
        rxm = m;
        rxo = own;
        rxv = 1'h1;
        #1 ak = ack_en;
        @(negedge clock);
        rxv = 1'h0;
        rxo = 1'h0;
        @(negedge clock);
    endtask : rx
    task automatic pulse_clr(input logic [6:0] f);
        rfc = (f == 7'h0);
        fcl = f;
        @(negedge clock);
        rfc = 1'h0;
        fcl = 7'h0;
        @(negedge clock);
    endtask : pulse_clr
    task automatic acc(input logic [1:0] m, input logic [31:0] p, k, input cmbf_msg_t f,
                       input logic eh, input logic [1:0] ei);
        fm = m;
        fp = p;
        fk = k;
        rx(f, 1'h0);
        chk("full", eh, full);
        if (eh) begin
            chk("hit", ei, hit);
            chk("irq_rx", 1'h1, irx);
            chk("host", f, host);
            pulse_clr(7'h0);
        end
    endtask : acc
    task automatic txgo(input logic [28:0] eid, input logic [3:0] d, input logic [2:0] ab);
        int i;
        dly = d;
        arb = 1'h1;
        @(negedge clock);
        arb = 1'h0;
        chk("req_valid", 1'h1, vld);
        chk("req_id", eid, treq.id);
        if (ab != 3'h0) begin
            abr = ab;
            @(negedge clock);
            chk("abort_ack", ab, aak & ab);
            chk("abort_empty", ab, emp & ab);
            abr = 3'h0;
        end
        for (i = 0; i < 40 && done !== 1'h1; i++) begin
            if (rdy === 1'h1) chk("pin", tbit, pin);
            else chk("pin_idle", 1'h1, pin);
            @(negedge clock);
        end
        if (done !== 1'h1) begin
            $display("[ERR] tx_done expected 1 seen timeout");
            err_count++;
            give_verdict();
        end
        @(negedge clock);
    endtask : txgo
    initial begin
        repeat (4) @(negedge clock);
        rst_n = 1'h1;
        chk("empty", 3'h7, emp);
        chk("pin", 1'h1, pin);
        chk("flags", 8'h0, {full, wkf, ef});
        chk("irq_tx", 1'h1, itx);
        $display("test reset done");
        a = mk(1'h1, 29'h1234567);
        c = a;
        c.data = 64'h55;
        fp = {a.id, 3'h6};
        rx(a, 1'h0);
        chk("full", 1'h1, full);
        chk("irq_rx", 1'h1, irx);
        rx(c, 1'h0);
        rx(mk(1'h1, 29'h1234566), 1'h0);
        chk("overrun", 1'h1, ef.overrun);
        chk("irq_err", 1'h1, ierr);
        chk("host", a, host);
        pulse_clr(7'h0);
        chk("host", c, host);
        chk("full", 1'h1, full);
        pulse_clr(7'h0);
        pulse_clr(7'h20);
        chk("overrun", 1'h0, ef.overrun);
        rx(a, 1'h1);
        chk("own", 2'h0, {ak, full});
        lb = 1'h1;
        rx(a, 1'h1);
        chk("loop", 2'h3, {ak, full});
        pulse_clr(7'h0);
        lb = 1'h0;
        $display("test receive done");
        s = mk(1'h0, 29'h5a3);
        acc(MODE_DUAL, 32'h0000b460, 32'h000f000f, s, 1'h1, 2'h1);
        acc(MODE_DUAL, 32'hb460b460, 32'h000f000f, s, 1'h1, 2'h0);
        acc(MODE_DUAL, {16'h0, a.id[28:15], 2'h0}, 32'h3, a, 1'h1, 2'h1);
        acc(MODE_DUAL, 32'h0000b470, 32'h0, s, 1'h0, 2'h0);
        acc(MODE_QUAD, 32'h0000b400, 32'h0, s, 1'h1, 2'h2);
        acc(MODE_QUAD, 32'h00b4b400, 32'h0, s, 1'h1, 2'h1);
        acc(MODE_QUAD, 32'h000000b5, 32'h1, s, 1'h1, 2'h3);
        acc(MODE_QUAD, 32'h000000b5, 32'h0, s, 1'h0, 2'h0);
        acc(2'h3, 32'hb460b460, 32'h0, s, 1'h0, 2'h0);
        $display("test filter done");
        for (int i = 0; i < 3; i++) begin
            tlm = mk(1'h1, 29'(i));
            tlp = pr[i];
            tld = 3'h1 << i;
            @(negedge clock);
        end
        tld = 3'h0;
        tsc = 3'h7;
        @(negedge clock);
        tsc = 3'h0;
        chk("empty", 4'h0, {emp, itx});
        txgo(29'h0, 4'h2, 3'h0);
        chk("empty", 4'h3, {emp, itx});
        txgo(29'h1, 4'h8, 3'h4);
        chk("empty", 3'h7, emp);
        chk("ack1", 1'h0, aak[1]);
        tlm = mk(1'h1, 29'h3);
        tlp = 8'h10;
        tld = 3'h1;
        @(negedge clock);
        tld = 3'h0;
        tsc = 3'h1;
        @(negedge clock);
        tsc = 3'h0;
        arb = 1'h1;
        @(negedge clock);
        arb = 1'h0;
        txer = 1'h1;
        @(negedge clock);
        txer = 1'h0;
        chk("retry", 2'h0, {vld, emp[0]});
        txgo(29'h3, 4'h2, 3'h0);
        chk("empty", 3'h7, emp);
        $display("test transmit done");
        for (int i = 0; i < 6; i++) begin
            rec = ev[i];
            tec = ev[i];
            repeat (2) @(negedge clock);
            chk("err", {1'h0, ev[i] > 9'h0ff, {2{ev[i] > 9'h07f}}, {2{ev[i] >= 9'h060}}},
                ef);
            chk("irq_err", ev[i] >= 9'h060, ierr);
        end
        pulse_clr(7'h1f);
        chk("err", 6'h1f, ef);
        ien = 7'h0;
        @(negedge clock);
        chk("irq_err", 1'h0, ierr);
        ien = 7'h7f;
        gie = 1'h0;
        @(negedge clock);
        chk("irq_all", 2'h0, {ierr, itx});
        gie = 1'h1;
        rec = 9'h0;
        tec = 9'h0;
        @(negedge clock);
        pulse_clr(7'h1f);
        chk("err", 6'h0, ef);
        $display("test error done");
        slp = 1'h1;
        brx = 1'h0;
        repeat (4) @(negedge clock);
        chk("wake", 2'h3, {wkf, iwk});
        brx = 1'h1;
        repeat (4) @(negedge clock);
        slp = 1'h0;
        pulse_clr(7'h40);
        chk("wake", 1'h0, wkf);
        $display("test wakeup done");
        give_verdict();
    end
endmodule : tb
